// *** testbench/adc_ctrl_sva.sv ***
// Purpose: Concurrent checks on the converter control block ports.
// Assumes: Mode bits are tracked from bus writes seen here.
// Notes: Bound to adc_conversion_control below.
`timescale 1ns/100ps
module adc_ctrl_sva (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side.
  input wire logic converterOn,
  input wire logic sampleEn,
  input wire logic doneIrq
);
  logic wr0;
  logic wr4;
  logic irqEn_q;
  logic cont_q;
  logic hw_q;
  assign wr0 = psel && penable && pready && pwrite && paddr == 8'h00;
  assign wr4 = psel && penable && pready && pwrite && paddr == 8'h04;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEn_q <= 1'b0;
      cont_q <= 1'b0;
      hw_q <= 1'b0;
    end else begin
      if (wr0) begin
        irqEn_q <= pwdata[6];
        cont_q <= pwdata[5];
      end
      if (wr4) begin
        hw_q <= pwdata[6];
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_go;
    wr0 && !hw_q && pwdata[4:0] != 5'h1F;
  endsequence
  sequence s_one;
    wr0 && !hw_q && !pwdata[5] && pwdata[4:0] != 5'h1F;
  endsequence
  sequence s_stop;
    wr0 && pwdata[4:0] == 5'h1F;
  endsequence
  sequence s_sample;
    sampleEn [*8] ##1 !sampleEn;
  endsequence
  property p_start; s_go |-> ##2 s_sample; endproperty
  a_start: assert property (p_start) else $error("sampling window wrong");
  property p_on; s_go |=> converterOn; endproperty
  a_on: assert property (p_on) else $error("converter not on");
  property p_off; s_stop |-> ##2 (!converterOn && !sampleEn) [*8]; endproperty
  a_off: assert property (p_off) else $error("converter not off");
  property p_single; s_one |-> ##[40:70] !converterOn; endproperty
  a_single: assert property (p_single) else $error("no low power");
  property p_cont; $fell(converterOn) |-> !cont_q || $past(wr0) || $past(wr0, 2); endproperty
  a_cont: assert property (p_cont) else $error("continuous stopped");
  property p_mask; !irqEn_q && $stable(irqEn_q) |-> !doneIrq; endproperty
  a_mask: assert property (p_mask) else $error("masked request");
  property p_clr; wr0 |-> ##2 !doneIrq; endproperty
  a_clr: assert property (p_clr) else $error("request not cleared");
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no bus answer");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00); endproperty
  a_err: assert property (p_err) else $error("bad error flag");
endmodule : adc_ctrl_sva
bind adc_conversion_control adc_ctrl_sva i_adc_ctrl_sva (.core_clk(core_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .converterOn(converterOn), .sampleEn(sampleEn),
  .doneIrq(doneIrq));

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench of the converter control block.
// Assumes: Comparator held constant during each conversion.
// Notes: A constant comparator gives a result of all ones or zero.
`timescale 1ns/100ps
module testbench;
  import adc_ctrl_pkg::*;
  logic coreClk;
  logic arstN;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hwTriggerIn;
  logic cmpHigh;
  logic converterOn;
  logic [4:0] inputSelect;
  logic sampleEn;
  logic [9:0] dacCode;
  logic doneIrq;
  logic [31:0] rd;
  logic lastErr;
  logic [4:0] sel;
  logic irq;
  logic c;
  int fails;
  int nTests;

  adc_conversion_control i_adc_conversion_control (.core_clk(coreClk), .arst_n(arstN),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hwTriggerIn(hwTriggerIn),
    .cmpHigh(cmpHigh), .converterOn(converterOn), .inputSelect(inputSelect),
    .sampleEn(sampleEn), .dacCode(dacCode), .doneIrq(doneIrq));

  initial begin
    coreClk = 1'b0;
    forever #2 coreClk = ~coreClk;
  end

  function automatic logic [31:0] expSc1(logic d, logic i, logic t, logic [4:0] s);
    return {24'h0, d, i, t, s};
  endfunction : expSc1

  function automatic logic [9:0] expRes(logic h);
    return h ? 10'h3FF : 10'h000;
  endfunction : expRes

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge coreClk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge coreClk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge coreClk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      report_and_stop;
    end
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task waitDone;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h00, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 60);
    if (n >= 60) begin
      fails++;
      report_and_stop;
    end
  endtask : waitDone

  task resChk(input logic [9:0] r);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, {30'h0, r[9:8]});
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, {24'h0, r[7:0]});
  endtask : resChk

  initial begin
    repeat (20000) @(posedge coreClk);
    fails++;
    report_and_stop;
  end

  initial begin
    {arstN, psel, penable, pwrite, hwTriggerIn, cmpHigh} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    nTests = 0;
    void'($urandom(32'h2994));
    repeat (5) @(posedge coreClk);
    arstN <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], lastErr}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      sel = (i == 0) ? 5'h1C : 5'($urandom_range(30));
      irq = 1'($urandom);
      c = 1'($urandom);
      cmpHigh <= c;
      apb(1'b1, 8'h00, expSc1(1'b0, irq, 1'b0, sel));
      waitDone;
      chk(rd, expSc1(1'b1, irq, 1'b0, sel));
      chk({31'h0, doneIrq}, {31'h0, irq});
      chk({27'h0, inputSelect}, {27'h0, sel});
      chk({22'h0, dacCode}, {22'h0, expRes(c)});
      repeat (4) @(posedge coreClk);
      chk({31'h0, converterOn}, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      resChk(expRes(c));
      repeat (60) @(posedge coreClk);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, expSc1(1'b0, irq, 1'b0, sel));
    end
    cmpHigh <= 1'b1;
    apb(1'b1, 8'h00, 32'h23);
    waitDone;
    resChk(10'h3FF);
    waitDone;
    chk({31'h0, converterOn}, 32'h1);
    repeat (20) @(posedge coreClk);
    cmpHigh <= 1'b0;
    apb(1'b1, 8'h00, 32'h02);
    waitDone;
    resChk(10'h000);
    apb(1'b1, 8'h00, 32'h23);
    repeat (20) @(posedge coreClk);
    apb(1'b1, 8'h00, 32'h3F);
    repeat (120) @(posedge coreClk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h3F);
    chk({31'h0, converterOn}, 32'h0);
    apb(1'b1, 8'h14, 32'h05);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h04, 32'h20);
    apb(1'b1, 8'h00, 32'h02);
    waitDone;
    chk(rd, 32'h82);
    apb(1'b1, 8'h04, 32'h30);
    apb(1'b1, 8'h00, 32'h02);
    repeat (120) @(posedge coreClk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h02);
    cmpHigh <= 1'b1;
    apb(1'b1, 8'h00, 32'h02);
    waitDone;
    resChk(10'h3FF);
    apb(1'b1, 8'h04, 32'h40);
    for (int k = 0; k < 31; k++) begin
      apb(1'b1, 8'h00, 32'(k));
      @(posedge coreClk);
      chk({27'h0, inputSelect}, 32'(k));
    end
    apb(1'b1, 8'h00, 32'h04);
    repeat (60) @(posedge coreClk);
    chk({31'h0, converterOn}, 32'h0);
    hwTriggerIn <= 1'b1;
    repeat (4) @(posedge coreClk);
    hwTriggerIn <= 1'b0;
    waitDone;
    chk(rd, 32'h84);
    report_and_stop;
  end
endmodule : testbench

// *** verilog/adc_conversion_control.sv ***
// Purpose: Register file and conversion sequencing of a 10-bit SAR converter.
// Assumes: APB slave, zero wait states; analog core outside.
// Notes: Operation
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Hardware trigger and comparator pins.
  input wire logic hwTriggerIn,
  input wire logic cmpHigh,
  // Analog core control.
  output logic converterOn,
  output logic [4:0] inputSelect,
  output logic sampleEn,
  output logic [9:0] dacCode,
  // Conversion-complete request.
  output logic doneIrq
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    ctl_state_t st;
    logic doneFlag;
    logic irqEnable;
    logic contSelect;
    logic [4:0] inSel;
    logic trigSelect;
    logic cmpEnable;
    logic cmpGeSelect;
    logic [9:0] result;
    logic [9:0] cmpValue;
    logic powered;
    logic trigPrev;
    logic start;
    logic abort;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } ctl_regs_t;

  ctl_regs_t q;
  ctl_regs_t d;
  logic [1:0] pinSync;
  logic trigSync;
  logic cmpSync;

  sar_link_if link ();

  input_sync u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn({cmpHigh, hwTriggerIn}),
    .pinSync(pinSync)
  );

  assign trigSync = pinSync[0];
  assign cmpSync = pinSync[1];

  sar_engine u_engine (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .link(link),
    .cmpHigh(cmpSync),
    .sampleEn(sampleEn),
    .dacCode(dacCode)
  );

  function automatic logic addrMapped(input logic [7:0] a);
    addrMapped = (a == OFS_STATUS_CONTROL_ONE) || (a == OFS_STATUS_CONTROL_TWO) ||
                 (a == OFS_RESULT_HIGH) || (a == OFS_RESULT_LOW) ||
                 (a == OFS_COMPARE_HIGH) || (a == OFS_COMPARE_LOW);
  endfunction : addrMapped

  function automatic logic compareTrue(input logic [9:0] res, input logic [9:0] cmp, input logic ge);
    compareTrue = ge ? (res >= cmp) : (res < cmp);
  endfunction : compareTrue

  function automatic logic [31:0] readMux(input ctl_regs_t r, input logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    unique case (a)
      OFS_STATUS_CONTROL_ONE: begin
        b[DONE_BIT] = r.doneFlag;
        b[IRQ_EN_BIT] = r.irqEnable;
        b[CONT_BIT] = r.contSelect;
        b[SEL_MSB:SEL_LSB] = r.inSel;
      end
      OFS_STATUS_CONTROL_TWO: begin
        b[ACTIVE_BIT] = (r.st == CTL_BUSY);
        b[TRIG_BIT] = r.trigSelect;
        b[CMP_EN_BIT] = r.cmpEnable;
        b[CMP_GE_BIT] = r.cmpGeSelect;
      end
      OFS_RESULT_HIGH: begin
        b = {6'h00, r.result[9:8]};
      end
      OFS_RESULT_LOW: begin
        b = r.result[7:0];
      end
      OFS_COMPARE_HIGH: begin
        b = {6'h00, r.cmpValue[9:8]};
      end
      OFS_COMPARE_LOW: begin
        b = r.cmpValue[7:0];
      end
      default: begin
        b = 8'h00;
      end
    endcase
    readMux = {24'h000000, b};
  endfunction : readMux

  logic setupPhase;
  logic accessDone;
  logic wrAccess;
  logic rdAccess;
  logic trigRise;
  logic doneSet;
  logic doneClear;
  logic hit;

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.abort = 1'b0;
    d.ready = 1'b0;
    d.slverr = 1'b0;
    d.trigPrev = trigSync;
    setupPhase = psel && !penable;
    accessDone = psel && penable && q.ready;
    wrAccess = accessDone && pwrite;
    rdAccess = accessDone && !pwrite;
    trigRise = trigSync && !q.trigPrev;
    doneSet = 1'b0;
    doneClear = 1'b0;
    hit = 1'b0;

    // Bus answer is prepared in the setup cycle.
    if (setupPhase) begin
      d.ready = 1'b1;
      d.rdata = readMux(q, paddr);
      d.slverr = !addrMapped(paddr);
    end

    // Conversion end from the engine.
    if (link.done && q.st == CTL_BUSY) begin
      hit = !q.cmpEnable || compareTrue(link.result, q.cmpValue, q.cmpGeSelect);
      if (hit) begin
        doneSet = 1'b1;
        d.result = link.result;
      end
      if (q.contSelect && q.inSel != SEL_OFF) begin
        d.start = 1'b1;
      end else begin
        d.st = CTL_IDLE;
        d.powered = 1'b0;
      end
    end

    if (q.trigSelect && trigRise && q.st == CTL_IDLE && q.inSel != SEL_OFF) begin
      d.start = 1'b1;
      d.st = CTL_BUSY;
      d.powered = 1'b1;
    end

    if (wrAccess) begin
      unique case (paddr)
        OFS_STATUS_CONTROL_ONE: begin
          d.irqEnable = pwdata[IRQ_EN_BIT];
          d.contSelect = pwdata[CONT_BIT];
          d.inSel = pwdata[SEL_MSB:SEL_LSB];
          doneClear = 1'b1;
          d.abort = (q.st == CTL_BUSY) || d.start;
          d.start = 1'b0;
          d.st = CTL_IDLE;
          if (pwdata[SEL_MSB:SEL_LSB] == SEL_OFF) begin
            d.powered = 1'b0;
          end else begin
            d.powered = 1'b1;
            if (!q.trigSelect) begin
              d.start = 1'b1;
              d.st = CTL_BUSY;
            end else begin
              d.powered = 1'b0;
            end
          end
        end
        OFS_STATUS_CONTROL_TWO: begin
          d.trigSelect = pwdata[TRIG_BIT];
          d.cmpEnable = pwdata[CMP_EN_BIT];
          d.cmpGeSelect = pwdata[CMP_GE_BIT];
        end
        OFS_COMPARE_HIGH: begin
          d.cmpValue[9:8] = pwdata[1:0];
        end
        OFS_COMPARE_LOW: begin
          d.cmpValue[7:0] = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end

    if (rdAccess && paddr == OFS_RESULT_LOW) begin
      doneClear = 1'b1;
    end

    // Hardware set wins over a clear in the same cycle.
    d.doneFlag = (q.doneFlag && !doneClear) || doneSet;

    d.irq = d.doneFlag && d.irqEnable;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: CTL_IDLE, doneFlag: 1'b0, irqEnable: 1'b0, contSelect: 1'b0, inSel: SEL_RESET,
             trigSelect: 1'b0, cmpEnable: 1'b0, cmpGeSelect: 1'b0, result: RESULT_RESET,
             cmpValue: COMPARE_RESET, powered: 1'b0, trigPrev: 1'b0, start: 1'b0, abort: 1'b0,
             irq: 1'b0, rdata: 32'h00000000, ready: 1'b0, slverr: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign link.start = q.start;
  assign link.abort = q.abort;
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign converterOn = q.powered;
  assign inputSelect = q.inSel;
  assign doneIrq = q.irq;
endmodule : adc_conversion_control

// *** verilog/adc_ctrl_pkg.sv ***
// Purpose: Shared constants and types of the converter control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: The analog converter core sits outside this logic.
package adc_ctrl_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_STATUS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_STATUS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h0C;
  localparam logic [7:0] OFS_COMPARE_HIGH = 8'h10;
  localparam logic [7:0] OFS_COMPARE_LOW = 8'h14;

  // Field positions of status_control_one.
  localparam int DONE_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;

  // Field positions of status_control_two.
  localparam int ACTIVE_BIT = 7;
  localparam int TRIG_BIT = 6;
  localparam int CMP_EN_BIT = 5;
  localparam int CMP_GE_BIT = 4;

  // Widths, codes and reset values.
  localparam int RES_W = 10;
  localparam int SEL_W = 5;
  localparam logic [4:0] SEL_OFF = 5'h1F;
  localparam logic [4:0] SEL_RESET = 5'h1F;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] COMPARE_RESET = 10'h000;
  localparam logic [9:0] TRIAL_FIRST = 10'h200;
  localparam logic [3:0] BIT_FIRST = 4'h9;

  // Timing counts in core clock cycles.
  localparam logic [3:0] SAMPLE_CYCLES = 4'h8;
  localparam logic [3:0] BIT_CYCLES = 4'h4;

  typedef enum logic [1:0] {
    CTL_IDLE = 2'b01,
    CTL_BUSY = 2'b10
  } ctl_state_t;

  typedef enum logic [2:0] {
    SAR_IDLE = 3'b001,
    SAR_SAMPLE = 3'b010,
    SAR_TRIAL = 3'b100
  } sar_state_t;

endpackage : adc_ctrl_pkg

// *** verilog/input_sync.sv ***
// Purpose: Two-flop synchroniser for the trigger and comparator pins.
// Assumes: Inputs are asynchronous to core_clk.
// Notes: Only the second stage leaves this module.
`timescale 1ns/100ps
module input_sync (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Pins and synchronised levels.
  input wire logic [1:0] pinIn,
  output logic [1:0] pinSync
);
  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
  } sync_regs_t;

  sync_regs_t q;
  sync_regs_t d;

  always_comb begin
    d.first = pinIn;
    d.second = q.first;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pinSync = q.second;
endmodule : input_sync

// *** verilog/sar_engine.sv ***
// Purpose: Successive-approximation sequencer: sample, then ten bit trials.
// Assumes: Comparator is high when the input is at or above the DAC level.
// Notes: An abort or a new start drops any trial in progress.
`timescale 1ns/100ps
module sar_engine
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Control link.
  sar_link_if.engine link,
  // Analog side.
  input wire logic cmpHigh,
  output logic sampleEn,
  output logic [9:0] dacCode
);
  typedef struct packed {
    sar_state_t st;
    logic [3:0] cnt;
    logic [3:0] bitIdx;
    logic [9:0] trial;
    logic [9:0] result;
    logic done;
    logic sample;
  } sar_regs_t;

  sar_regs_t q;
  sar_regs_t d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    unique case (q.st)
      SAR_IDLE: begin
        d.sample = 1'b0;
      end
      SAR_SAMPLE: begin
        if (q.cnt == 4'h0) begin
          d.st = SAR_TRIAL;
          d.sample = 1'b0;
          d.bitIdx = BIT_FIRST;
          d.trial = TRIAL_FIRST;
          d.cnt = BIT_CYCLES - 4'h1;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      SAR_TRIAL: begin
        if (q.cnt == 4'h0) begin
          if (!cmpHigh) begin
            d.trial[q.bitIdx] = 1'b0;
          end
          if (q.bitIdx == 4'h0) begin
            d.st = SAR_IDLE;
            d.done = 1'b1;
            d.result = d.trial;
          end else begin
            d.bitIdx = q.bitIdx - 4'h1;
            d.trial[q.bitIdx - 4'h1] = 1'b1;
            d.cnt = BIT_CYCLES - 4'h1;
          end
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
    endcase
    if (link.abort) begin
      d.st = SAR_IDLE;
      d.sample = 1'b0;
      d.done = 1'b0;
    end
    if (link.start) begin
      d.st = SAR_SAMPLE;
      d.sample = 1'b1;
      d.cnt = SAMPLE_CYCLES - 4'h1;
      d.trial = '0;
      d.done = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: SAR_IDLE, cnt: 4'h0, bitIdx: 4'h0, trial: 10'h000, result: RESULT_RESET, done: 1'b0, sample: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign link.done = q.done;
  assign link.result = q.result;
  assign sampleEn = q.sample;
  assign dacCode = q.trial;
endmodule : sar_engine

// *** verilog/sar_link_if.sv ***
// Purpose: Carries start, abort and completion between control and engine.
// Assumes: One clock domain.
// Notes: Start and abort are one-cycle pulses; done is a one-cycle pulse.
`timescale 1ns/100ps
interface sar_link_if;
  logic start;
  logic abort;
  logic done;
  logic [9:0] result;
  modport ctrl (output start, output abort, input done, input result);
  modport engine (input start, input abort, output done, output result);
endinterface : sar_link_if
